// ---- rtl/vpp_pkg.sv ----
package vpp_pkg;

  // ****************************************
  // Clock and link timing
  // ****************************************
  localparam int CLOCK_PERIOD_NS = 4;
  localparam int CLK_HZ = 1000000000 / CLOCK_PERIOD_NS;
  localparam int SAMPLE_HZ = 16000;
  localparam int WORD_BITS = 16;
  localparam int PCM_FRAME_BITS = 16;
  localparam int I2S_FRAME_BITS = 32;

  // ****************************************
  // Bit clock phase accumulator
  // ****************************************
  // Two accumulator wraps per bit clock period, one per edge
  localparam int NCO_W = 29;
  localparam logic [NCO_W-1:0] NCO_MODULUS = NCO_W'(CLK_HZ);
  localparam logic [NCO_W-1:0] PCM_NCO_STEP = NCO_W'(2 * PCM_FRAME_BITS * SAMPLE_HZ);
  localparam logic [NCO_W-1:0] I2S_NCO_STEP = NCO_W'(2 * I2S_FRAME_BITS * SAMPLE_HZ);

  // ****************************************
  // Frame slots and reset values
  // ****************************************
  localparam int SLOT_W = 5;
  localparam logic [SLOT_W-1:0] PCM_LAST_SLOT = SLOT_W'(PCM_FRAME_BITS - 1);
  localparam logic [SLOT_W-1:0] I2S_LAST_SLOT = SLOT_W'(I2S_FRAME_BITS - 1);
  localparam logic [SLOT_W-1:0] PCM_LOAD_SLOT = 5'h00;
  localparam logic [SLOT_W-1:0] I2S_LOAD_SLOT = 5'h01;
  localparam logic [SLOT_W-1:0] SLOT_RESET = 5'h1f;

  // ****************************************
  // Reference clock
  // ****************************************
  localparam int REF_HALF_CYCLES = 10;
  localparam int REF_CNT_W = 8;

  typedef enum logic [1:0] {
    VPP_IDLE = 2'b01,
    VPP_RUN = 2'b10
  } vpp_state_type;

endpackage : vpp_pkg

// ---- rtl/vpp_clk_if.sv ----
interface vpp_clk_if;
  logic run;
  logic i2s_mode;
  logic bclk;
  logic rise;
  logic fall;

  modport gen (
    input run,
    input i2s_mode,
    output bclk,
    output rise,
    output fall
  );

  modport port (
    output run,
    output i2s_mode,
    input bclk,
    input rise,
    input fall
  );
endinterface : vpp_clk_if

// ---- rtl/vpp_bit_clock_gen.sv ----
module vpp_bit_clock_gen (
  input wire logic clock_in,   // System clock
  input wire logic reset_n_in, // Synchronous reset, active low
  vpp_clk_if.gen clk_if        // Run request and bit clock strobes
);
  import vpp_pkg::*;

  typedef struct packed {
    logic [NCO_W-1:0] acc;
    logic bclk;
    logic rise;
    logic fall;
  } vpp_gen_state_type;

  vpp_gen_state_type state_reg;
  vpp_gen_state_type state_next;

  // ****************************************
  // Fractional divider
  // ****************************************
  // 250 MHz is no integer multiple of either bit clock, so edges jitter
  // by one system cycle while the average rate stays exact.
  always_comb begin
    logic [NCO_W:0] sum;
    logic [NCO_W-1:0] step;
    step = clk_if.i2s_mode ? I2S_NCO_STEP : PCM_NCO_STEP;
    sum = {1'b0, state_reg.acc} + {1'b0, step};
    state_next = state_reg;
    state_next.rise = 1'b0;
    state_next.fall = 1'b0;
    if (!clk_if.run) begin
      state_next.acc = '0;
      state_next.bclk = 1'b0;
    end else if (sum >= {1'b0, NCO_MODULUS}) begin
      state_next.acc = NCO_W'(sum - {1'b0, NCO_MODULUS});
      state_next.bclk = ~state_reg.bclk;
      state_next.rise = ~state_reg.bclk;
      state_next.fall = state_reg.bclk;
    end else begin
      state_next.acc = sum[NCO_W-1:0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign clk_if.bclk = state_reg.bclk;
  assign clk_if.rise = state_reg.rise;
  assign clk_if.fall = state_reg.fall;

endmodule : vpp_bit_clock_gen

// ---- rtl/vpp_voice_port.sv ----
module vpp_voice_port #(
  parameter int REF_HALF = vpp_pkg::REF_HALF_CYCLES // System cycles per reference clock half period
) (
  input wire logic clock_in,                            // System clock
  input wire logic reset_n_in,                          // Synchronous reset, active low
  input wire logic enable_in,                           // Run the link
  input wire logic mode_i2s_in,                         // 1 long-sync I2S, 0 short-sync PCM
  input wire logic ref_clock_enable_in,                 // Run the codec reference clock
  input wire logic [vpp_pkg::WORD_BITS-1:0] tx_left_in,  // Left or mono sample to send
  input wire logic [vpp_pkg::WORD_BITS-1:0] tx_right_in, // Right sample to send
  output logic tx_load_out,                             // Pulse: tx words taken
  output logic [vpp_pkg::WORD_BITS-1:0] rx_left_out,     // Left or mono sample received
  output logic [vpp_pkg::WORD_BITS-1:0] rx_right_out,    // Right sample received
  output logic rx_valid_out,                            // Pulse: rx words updated
  output logic running_out,                             // Link active
  output logic mode_active_out,                         // Framing in use, 1 for I2S
  output logic mode_mismatch_out,                       // Mode input differs from framing in use, while running
  output logic bit_clock_out,                           // Serial bit clock pin
  output logic frame_sync_out,                          // Frame sync pin
  output logic serial_data_out,                         // Serial data to codec
  input wire logic serial_data_in,                      // Serial data from codec
  output logic codec_ref_clock_out                      // Codec reference clock pin
);
  import vpp_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    vpp_state_type state;
    logic i2s;
    logic primed;
    logic stopping;
    logic [SLOT_W-1:0] slot;
    logic [2*WORD_BITS-1:0] tx_shift;
    logic [2*WORD_BITS-1:0] rx_shift;
    logic [WORD_BITS-1:0] rx_left;
    logic [WORD_BITS-1:0] rx_right;
    logic rx_valid;
    logic tx_load;
    logic fs;
    logic sd_out;
    logic din_meta;
    logic din_sync;
    logic [REF_CNT_W-1:0] ref_cnt;
    logic ref_clk;
  } vpp_port_state_type;

  localparam vpp_port_state_type PORT_RESET = '{
    state: VPP_IDLE,
    slot: SLOT_RESET,
    default: '0
  };
  localparam logic [REF_CNT_W-1:0] REF_LAST = REF_CNT_W'(REF_HALF - 1);

  vpp_port_state_type state_reg;
  vpp_port_state_type state_next;

  vpp_clk_if clk_if ();

  // ****************************************
  // Frame geometry
  // ****************************************
  function automatic logic [SLOT_W-1:0] last_slot(input logic i2s);
    return i2s ? I2S_LAST_SLOT : PCM_LAST_SLOT;
  endfunction : last_slot

  // Slot where the words are latched and the first MSB goes out
  function automatic logic [SLOT_W-1:0] load_slot(input logic i2s);
    return i2s ? I2S_LOAD_SLOT : PCM_LOAD_SLOT;
  endfunction : load_slot

  // Slot whose rising edge samples the final bit of the frame
  function automatic logic [SLOT_W-1:0] word_end_slot(input logic i2s);
    return i2s ? 5'h00 : PCM_LAST_SLOT;
  endfunction : word_end_slot

  function automatic logic sync_level(input logic i2s, input logic [SLOT_W-1:0] s);
    // I2S sync moves one bit before the MSB, during the previous LSB
    if (i2s) begin
      return s[SLOT_W-1];
    end
    return s == PCM_LOAD_SLOT;
  endfunction : sync_level

  // ****************************************
  // Bit clock generator
  // ****************************************
  vpp_bit_clock_gen u_bit_clock_gen (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .clk_if(clk_if.gen)
  );

  assign clk_if.run = state_reg.state == VPP_RUN;
  assign clk_if.i2s_mode = state_reg.i2s;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [SLOT_W-1:0] slot_n;
    logic [2*WORD_BITS-1:0] shift_n;
    slot_n = '0;
    shift_n = '0;
    state_next = state_reg;
    state_next.tx_load = 1'b0;
    state_next.rx_valid = 1'b0;
    // Data pin crosses in from the codec: two flops before use
    state_next.din_meta = serial_data_in;
    state_next.din_sync = state_reg.din_meta;

    // Reference clock, free of the link state
    if (!ref_clock_enable_in) begin
      state_next.ref_cnt = '0;
      state_next.ref_clk = 1'b0;
    end else if (state_reg.ref_cnt >= REF_LAST) begin
      state_next.ref_cnt = '0;
      state_next.ref_clk = ~state_reg.ref_clk;
    end else begin
      state_next.ref_cnt = state_reg.ref_cnt + 8'h01;
    end

    case (state_reg.state)
      VPP_IDLE: begin
        // Framing is fixed only while idle, so one run never mixes the two
        state_next.i2s = mode_i2s_in;
        state_next.slot = last_slot(mode_i2s_in);
        state_next.primed = 1'b0;
        state_next.stopping = 1'b0;
        state_next.fs = 1'b0;
        state_next.sd_out = 1'b0;
        if (enable_in) begin
          state_next.state = VPP_RUN;
        end
      end

      VPP_RUN: begin
        if (!enable_in) begin
          state_next.stopping = 1'b1;
        end

        // Outputs change on the falling edge, codec samples on the rising
        if (clk_if.fall) begin
          if (state_reg.stopping && state_reg.slot == word_end_slot(state_reg.i2s)) begin
            // Stop after the slot with the last bit; I2S right LSB sits in slot 0
            state_next.state = VPP_IDLE;
            state_next.fs = 1'b0;
            state_next.sd_out = 1'b0;
          end else begin
            slot_n = (state_reg.slot == last_slot(state_reg.i2s)) ? 5'h00 : state_reg.slot + 5'h01;
            state_next.slot = slot_n;
            state_next.fs = sync_level(state_reg.i2s, slot_n);
            if (slot_n == load_slot(state_reg.i2s)) begin
              // Left then right, each MSB first; PCM sends only the left word
              shift_n = {tx_left_in, tx_right_in};
              state_next.tx_load = 1'b1;
              state_next.primed = 1'b1;
            end else begin
              shift_n = {state_reg.tx_shift[2*WORD_BITS-2:0], 1'b0};
            end
            state_next.tx_shift = shift_n;
            state_next.sd_out = shift_n[2*WORD_BITS-1];
          end
        end

        if (clk_if.rise) begin
          shift_n = {state_reg.rx_shift[2*WORD_BITS-2:0], state_reg.din_sync};
          state_next.rx_shift = shift_n;
          if (state_reg.slot == word_end_slot(state_reg.i2s) && state_reg.primed) begin
            state_next.rx_valid = 1'b1;
            if (state_reg.i2s) begin
              state_next.rx_left = shift_n[2*WORD_BITS-1:WORD_BITS];
              state_next.rx_right = shift_n[WORD_BITS-1:0];
            end else begin
              // Mono link: the one word shows on both outputs
              state_next.rx_left = shift_n[WORD_BITS-1:0];
              state_next.rx_right = shift_n[WORD_BITS-1:0];
            end
          end
        end
      end

      default: begin
        state_next = PORT_RESET;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      state_reg <= PORT_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign bit_clock_out = clk_if.bclk;
  assign frame_sync_out = state_reg.fs;
  assign serial_data_out = state_reg.sd_out;
  assign codec_ref_clock_out = state_reg.ref_clk;
  assign tx_load_out = state_reg.tx_load;
  assign rx_left_out = state_reg.rx_left;
  assign rx_right_out = state_reg.rx_right;
  assign rx_valid_out = state_reg.rx_valid;
  assign running_out = state_reg.state == VPP_RUN;
  assign mode_active_out = state_reg.i2s;
  assign mode_mismatch_out = (state_reg.state == VPP_RUN) && (mode_i2s_in != state_reg.i2s);

endmodule : vpp_voice_port

// ---- verification/vpp_voice_port_assertions.sv ----
module vpp_voice_port_assertions #(
  parameter int REF_HALF = 10 // Ref half period
) (
  input wire logic clock_in, // Clock
  input wire logic reset_n_in, // Reset
  input wire logic ref_clock_enable_in, // Ref enable
  input wire logic [vpp_pkg::WORD_BITS-1:0] tx_left_in, // Left word
  input wire logic tx_load_out, // Load pulse
  input wire logic rx_valid_out, // Rx pulse
  input wire logic running_out, // Running
  input wire logic mode_active_out, // Framing
  input wire logic bit_clock_out, // Bit clock
  input wire logic frame_sync_out, // Sync
  input wire logic serial_data_out, // Data
  input wire logic codec_ref_clock_out // Ref clock
);
  import vpp_pkg::*;
  // ****
  // Edge counters
  // ****
  logic bclk_reg, sync_reg, ref_reg, edge_seen_reg, sync_seen_reg, fall_d_reg;
  logic [8:0] half_reg;
  logic [13:0] frame_reg;
  logic [4:0] falls_reg;
  logic [7:0] ref_run_reg;
  logic [1:0] ref_tog_reg;
  wire bclk_edge = bclk_reg != bit_clock_out;
  wire bclk_fall = bclk_reg && !bit_clock_out;
  wire sync_rise = !sync_reg && frame_sync_out;
  wire sync_fall = sync_reg && !frame_sync_out;
  wire ref_edge = ref_reg != codec_ref_clock_out;
  always_ff @(posedge clock_in) begin
    bclk_reg <= bit_clock_out;
    sync_reg <= frame_sync_out;
    ref_reg <= codec_ref_clock_out;
    half_reg <= bclk_edge ? 9'h000 : half_reg + 9'h001;
    frame_reg <= sync_rise ? 14'h0000 : frame_reg + 14'h0001;
    // Sync and data move one cycle after the pin falls
    fall_d_reg <= bclk_fall;
    falls_reg <= sync_rise ? 5'h00 : falls_reg + 5'(fall_d_reg);
    ref_run_reg <= ref_edge ? 8'h00 : ref_run_reg + 8'h01;
    // First edge after start has no full interval
    edge_seen_reg <= running_out && reset_n_in && (edge_seen_reg || bclk_edge);
    sync_seen_reg <= running_out && reset_n_in && (sync_seen_reg || sync_rise);
    if (!ref_clock_enable_in || !reset_n_in) ref_tog_reg <= 2'h0;
    else if (ref_edge && ref_tog_reg != 2'h2) ref_tog_reg <= ref_tog_reg + 2'h1;
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  a_pcm_bit_rate: assert property (bclk_edge && edge_seen_reg && !mode_active_out |-> half_reg inside {[487:488]})
    else $error("pcm bit clock half period");
  a_i2s_bit_rate: assert property (bclk_edge && edge_seen_reg && mode_active_out |-> half_reg inside {[243:244]})
    else $error("i2s bit clock half period");
  a_sync_rate: assert property (sync_rise && sync_seen_reg |-> frame_reg inside {[15622:15626]})
    else $error("frame sync period");
  a_frame_bits: assert property (sync_rise && sync_seen_reg |-> falls_reg == (mode_active_out ? 5'h1f : 5'h0f))
    else $error("bit clocks per frame");
  a_sync_width: assert property (sync_fall && sync_seen_reg |-> falls_reg == (mode_active_out ? 5'h0f : 5'h00))
    else $error("sync high width");
  a_sync_on_fall: assert property (running_out && $changed(frame_sync_out) |-> fall_d_reg)
    else $error("sync moved off a falling edge");
  a_data_on_fall: assert property (running_out && $changed(serial_data_out) |-> fall_d_reg)
    else $error("data moved off a falling edge");
  a_mode_hold: assert property (running_out && $past(running_out) |-> $stable(mode_active_out))
    else $error("framing changed while running");
  a_load_msb: assert property (tx_load_out |-> fall_d_reg && serial_data_out == tx_left_in[15])
    else $error("first bit is not the msb");
  a_ref_period: assert property (ref_edge && ref_tog_reg != 2'h0 && $past(ref_clock_enable_in) |-> ref_run_reg == REF_HALF - 1)
    else $error("reference clock half period");
  c_pcm_word: cover property (rx_valid_out && !mode_active_out);
  c_i2s_word: cover property (rx_valid_out && mode_active_out);
  c_ref_toggle: cover property (ref_edge && ref_tog_reg == 2'h2);
endmodule : vpp_voice_port_assertions

bind vpp_voice_port vpp_voice_port_assertions #(.REF_HALF(REF_HALF)) u_vpp_voice_port_assertions (.clock_in,
  .reset_n_in, .ref_clock_enable_in, .tx_left_in, .tx_load_out, .rx_valid_out, .running_out, .mode_active_out,
  .bit_clock_out, .frame_sync_out, .serial_data_out, .codec_ref_clock_out);

// ---- verification/vpp_codec_model.sv ----
module vpp_codec_model (
  input wire logic clock_in, // System clock
  input wire logic run_in, // Link active
  input wire logic i2s_in, // Long-sync framing
  input wire logic bclk_in, // Bit clock
  input wire logic sync_in, // Frame sync
  input wire logic sdata_in, // Data from port
  input wire logic [15:0] left_in, // Next left word
  input wire logic [15:0] right_in, // Next right word
  output logic sdata_out = 1'b0, // Data to port
  output logic latch_out = 1'b0, // Pulse: word taken
  output logic [15:0] latch_word_out, // Word taken
  output logic got_out = 1'b0, // Pulse: word received
  output logic [15:0] got_word_out // Word received
);
  import vpp_pkg::*;
  logic bclk_q = 1'b0;
  logic bclk_qq = 1'b0;
  logic sync_q = 1'b0;
  logic primed = 1'b0;
  logic [4:0] slot = 5'h1f;
  logic [15:0] lw = 16'h0000;
  logic [15:0] rw = 16'h0000;
  logic [15:0] sh = 16'h0000;
  // ****
  // Slave: follows the port's clocks only
  // ****
  always @(posedge clock_in) begin
    latch_out <= 1'b0;
    got_out <= 1'b0;
    bclk_q <= bclk_in;
    // Sync and data settle one cycle after the pin edge, so act a cycle late
    bclk_qq <= bclk_q;
    if (!run_in) begin
      slot = 5'h1f;
      sync_q <= 1'b0;
      primed <= 1'b0;
      sdata_out <= ~sdata_out; // Released line never holds a value
    end else if (bclk_qq && !bclk_q) begin
      sync_q <= sync_in;
      slot = (i2s_in ? sync_q && !sync_in : sync_in) ? 5'h00 : slot + 5'h01;
      if (slot == {4'h0, i2s_in} || (i2s_in && slot == 5'h11)) begin
        if (slot == 5'h11) rw = right_in;
        else lw = left_in;
        latch_out <= 1'b1;
        latch_word_out <= slot == 5'h11 ? right_in : left_in;
      end
      sdata_out <= !i2s_in ? lw[4'(15 - slot)] : (slot inside {[1:16]}) ? lw[4'(16 - slot)] : rw[4'(0 - slot)];
    end else if (!bclk_qq && bclk_q) begin
      sh = {sh[14:0], sdata_in};
      if (slot == (i2s_in ? 5'h10 : 5'h0f) || (i2s_in && slot == 5'h00 && primed)) begin
        got_out <= 1'b1;
        got_word_out <= sh;
        primed <= 1'b1;
      end
    end
  end
endmodule : vpp_codec_model

// ---- verification/vpp_voice_port_bench.sv ----
module vpp_voice_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import vpp_pkg::*;
  localparam int REF_H = 2;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic enable_in = 1'b0;
  logic mode_i2s_in = 1'b0;
  logic ref_clock_enable_in = 1'b0;
  logic i2s_run = 1'b0;
  logic [15:0] tx_left_in, tx_right_in, rx_left_out, rx_right_out, cod_left, cod_right, latch_word, got_word;
  logic tx_load_out, rx_valid_out, running_out, mode_active_out, mode_mismatch_out, latch, got;
  logic bit_clock_out, frame_sync_out, serial_data_out, serial_data_in, codec_ref_clock_out;
  logic [15:0] exp_rx[$];
  logic [15:0] exp_tx[$];
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  vpp_voice_port #(.REF_HALF(REF_H)) u_vpp_voice_port (.clock_in, .reset_n_in, .enable_in, .mode_i2s_in,
    .ref_clock_enable_in, .tx_left_in, .tx_right_in, .tx_load_out, .rx_left_out, .rx_right_out, .rx_valid_out,
    .running_out, .mode_active_out, .mode_mismatch_out, .bit_clock_out, .frame_sync_out, .serial_data_out,
    .serial_data_in, .codec_ref_clock_out);
  vpp_codec_model u_vpp_codec_model (.clock_in(clock_in), .run_in(running_out), .i2s_in(i2s_run),
    .bclk_in(bit_clock_out), .sync_in(frame_sync_out), .sdata_in(serial_data_out), .left_in(cod_left),
    .right_in(cod_right), .sdata_out(serial_data_in), .latch_out(latch), .latch_word_out(latch_word),
    .got_out(got), .got_word_out(got_word));

  initial forever #2 clock_in = ~clock_in;

  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic finish_test();
    if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  task automatic wait_level(ref logic sig, input logic level, input int limit);
    int n;
    n = 0;
    while (sig !== level && n < limit) begin
      @(posedge clock_in);
      n++;
    end
    if (sig !== level) begin
      check(1'b0, "wait timed out");
      finish_test();
    end
  endtask : wait_level

  // ****
  // Drivers note what each word should become
  // ****
  always @(posedge clock_in) begin
    if (latch === 1'b1) begin
      exp_rx.push_back(latch_word);
      if (!i2s_run) exp_rx.push_back(latch_word); // Mono word mirrored
    end
    if (!reset_n_in || latch === 1'b1) begin
      cod_left <= 16'($urandom);
      cod_right <= 16'($urandom);
    end
    if (tx_load_out === 1'b1) begin
      exp_tx.push_back(tx_left_in);
      if (i2s_run) exp_tx.push_back(tx_right_in);
    end
    if (!reset_n_in || tx_load_out === 1'b1) begin
      tx_left_in <= 16'($urandom);
      tx_right_in <= 16'($urandom);
    end
  end

  always @(posedge clock_in) begin
    cycles++;
    if (cycles > 100000) begin
      check(1'b0, "run too long");
      finish_test();
    end else begin
      if (rx_valid_out === 1'b1 && exp_rx.size() < 2) check(1'b0, "unexpected rx word");
      else if (rx_valid_out === 1'b1) begin
        check(rx_left_out === exp_rx.pop_front(), "rx left word");
        check(rx_right_out === exp_rx.pop_front(), "rx right word");
      end
      if (got === 1'b1 && exp_tx.size() == 0) check(1'b0, "unexpected tx word");
      else if (got === 1'b1) check(got_word === exp_tx.pop_front(), "tx word");
    end
  end

  initial begin
    void'($urandom(85343));
    repeat (5) @(posedge clock_in);
    reset_n_in <= 1'b1;
    ref_clock_enable_in <= 1'b1;
    @(posedge clock_in);
    check({running_out, bit_clock_out, frame_sync_out, tx_load_out, rx_valid_out} === 5'h00, "reset state");
    enable_in <= 1'b1;
    repeat (2000) @(posedge clock_in);
    mode_i2s_in <= 1'b1;
    ref_clock_enable_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    check(mode_mismatch_out === 1'b1 && mode_active_out === 1'b0, "mode change while running");
    check(codec_ref_clock_out === 1'b0, "reference clock not stopped");
    mode_i2s_in <= 1'b0;
    ref_clock_enable_in <= 1'b1;
    repeat (2) begin
      wait_level(rx_valid_out, 1'b1, 20000);
      @(posedge clock_in);
    end
    enable_in <= 1'b0;
    wait_level(running_out, 1'b0, 20000);
    check(exp_rx.size() == 0 && exp_tx.size() == 0, "frame cut short on stop");
    i2s_run <= 1'b1;
    mode_i2s_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    enable_in <= 1'b1;
    wait_level(rx_valid_out, 1'b1, 40000);
    check(mode_active_out === 1'b1, "framing not switched");
    enable_in <= 1'b0;
    wait_level(running_out, 1'b0, 20000);
    check(exp_rx.size() == 0 && exp_tx.size() == 0, "i2s word cut short on stop");
    finish_test();
  end
endmodule : vpp_voice_port_bench
